// ---- src/fc_port2_pkg.sv ----
// Package: offsets, field positions and reset values for the port 2 flow control register
package fc_port2_pkg;
	localparam logic [11:0] CFG_OFFSET = 12'h1a4;
	localparam int DATA_W = 32;
	localparam int BIT_MANUAL = 0;
	localparam int BIT_TX_EN = 1;
	localparam int BIT_RX_EN = 2;
	localparam int BIT_CUR_TX = 3;
	localparam int BIT_CUR_RX = 4;
	localparam int BIT_CUR_DUP = 5;
	localparam int BIT_BP_EN = 6;
	localparam int FIELD_W = 7;
	localparam logic [6:0] WRITABLE_MASK = 7'h47;
	localparam logic [6:0] RESET_FIELDS = 7'h00;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage : fc_port2_pkg

// ---- src/fc_resolve.sv ----
// Resolution of the flow control settings actually in force on port 2
`timescale 1ns/1ns
module fc_resolve (
	input wire logic manual_pause_select,
	input wire logic pause_tx_enable,
	input wire logic pause_rx_enable,
	input wire logic an_enabled,
	input wire logic an_complete,
	input wire logic an_pause_tx,
	input wire logic an_pause_rx,
	input wire logic half_duplex,
	output logic res_tx,
	output logic res_rx
);
	// --------------------------------------------------------------------
	// Selection
	// --------------------------------------------------------------------
	// Pause only has meaning in full duplex, so half duplex forces both off
	always_comb begin
		if (half_duplex) begin
			res_tx = 1'b0;
			res_rx = 1'b0;
		end else if (manual_pause_select || !an_enabled) begin
			res_tx = pause_tx_enable;
			res_rx = pause_rx_enable;
		end else begin
			// Until negotiation completes no pause is agreed
			res_tx = an_complete & an_pause_tx;
			res_rx = an_complete & an_pause_rx;
		end
	end
endmodule : fc_resolve

// ---- src/port2_flow_control_select.sv ----
// Port 2 flow control configuration and status register
`timescale 1ns/1ns
// Function
// - Register sits at offset 1A4h, one 32-bit read/write word.
// - Readback shows flow control actually in force, manual or negotiated.
// - Writes never touch the PHY advertisement pause bits.
// - Half-duplex backpressure only when bit 6 is set.
// - Bit 5 read-only: actual duplex, 1 means half.
// - Bit 4 read-only: pause receive currently enabled.
// - Bit 3 read-only: pause transmit currently enabled.
// - Manual or no negotiation: pause detection follows bit 2.
// - Manual or no negotiation: pause generation follows bit 1.
// - Bit 0 clear: negotiated result if negotiation on, else enable bits.
// - Bit 0 set: full-duplex pause taken only from enable bits.
// - Writable defaults come from straps sampled during reset.
// - Read-only bits at reset derive from several straps.
// - Loader rewriting straps reloads the register fields.
module port2_flow_control_select (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	input wire logic backpressure_strap,
	input wire logic full_duplex_pause_strap,
	input wire logic manual_select_strap,
	input wire logic strap_duplex_half,
	input wire logic strap_an_enable,
	input wire logic strap_load,
	input wire logic an_enabled,
	input wire logic an_complete,
	input wire logic an_pause_tx,
	input wire logic an_pause_rx,
	input wire logic link_half_duplex,
	output logic backpressure_active,
	output logic pause_tx_active,
	output logic pause_rx_active
);
	// --------------------------------------------------------------------
	// State
	// --------------------------------------------------------------------
	logic [6:0] fields_reg;
	logic [6:0] fields_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic loaded_reg;
	logic loaded_next;
	logic res_tx;
	logic res_rx;
	logic dup_now;
	logic an_on;
	logic hit;

	// Until a strap load after the last reset the duplex and negotiation come from straps
	assign dup_now = loaded_reg ? link_half_duplex : strap_duplex_half;
	assign an_on = loaded_reg ? an_enabled : strap_an_enable;
	assign hit = (reg_addr == fc_port2_pkg::CFG_OFFSET);

	fc_resolve u_resolve (
		.manual_pause_select(fields_reg[fc_port2_pkg::BIT_MANUAL]),
		.pause_tx_enable(fields_reg[fc_port2_pkg::BIT_TX_EN]),
		.pause_rx_enable(fields_reg[fc_port2_pkg::BIT_RX_EN]),
		.an_enabled(an_on),
		.an_complete(an_complete),
		.an_pause_tx(an_pause_tx),
		.an_pause_rx(an_pause_rx),
		.half_duplex(dup_now),
		.res_tx(res_tx),
		.res_rx(res_rx)
	);

	// --------------------------------------------------------------------
	// Register update
	// --------------------------------------------------------------------
	// Strap load outranks a software write in the same cycle: the loader
	// runs only during bring-up, before software owns the register.
	always_comb begin
		fields_next = fields_reg;
		loaded_next = loaded_reg;
		if (rst || strap_load) begin
			fields_next = fc_port2_pkg::RESET_FIELDS;
			fields_next[fc_port2_pkg::BIT_BP_EN] = backpressure_strap;
			fields_next[fc_port2_pkg::BIT_RX_EN] = full_duplex_pause_strap;
			fields_next[fc_port2_pkg::BIT_TX_EN] = full_duplex_pause_strap;
			fields_next[fc_port2_pkg::BIT_MANUAL] = manual_select_strap;
			loaded_next = !rst;
		end else if (reg_wr && hit) begin
			// Only writable bits; upper and status bits are dropped
			fields_next = (fields_reg & ~fc_port2_pkg::WRITABLE_MASK)
				| (reg_wdata[6:0] & fc_port2_pkg::WRITABLE_MASK);
		end
		// Status bits track the resolved state every cycle
		fields_next[fc_port2_pkg::BIT_CUR_DUP] = dup_now;
		fields_next[fc_port2_pkg::BIT_CUR_RX] = res_rx;
		fields_next[fc_port2_pkg::BIT_CUR_TX] = res_tx;
	end

	// --------------------------------------------------------------------
	// Read path
	// --------------------------------------------------------------------
	always_comb begin
		rdata_next = fc_port2_pkg::READ_ZERO;
		if (reg_rd && hit) begin
			rdata_next[6:0] = fields_reg;
		end
	end

	always_ff @(posedge mclk) begin
		fields_reg <= fields_next;
		loaded_reg <= loaded_next;
		rdata_reg <= rst ? fc_port2_pkg::READ_ZERO : rdata_next;
	end

	assign reg_rdata = rdata_reg;
	assign backpressure_active = fields_reg[fc_port2_pkg::BIT_BP_EN] & dup_now;
	assign pause_tx_active = fields_reg[fc_port2_pkg::BIT_CUR_TX];
	assign pause_rx_active = fields_reg[fc_port2_pkg::BIT_CUR_RX];
endmodule : port2_flow_control_select

// ---- test/fc_port2_checker.sv ----
// Assertions on the port 2 flow control register ports
`timescale 1ns/1ns
module fc_port2_checker (
	input wire logic mclk, rst, reg_wr, reg_rd, strap_load, backpressure_strap,
	input wire logic manual_select_strap, backpressure_active, pause_tx_active, pause_rx_active,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata, reg_rdata
);
	wire hit = reg_addr == 12'h1a4;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_reserved_zero: assert property (reg_rd && hit |=> !reg_rdata[31:7]) else $error("rsv");
	a_unmapped_zero: assert property (reg_rd && !hit |=> reg_rdata == 32'h0) else $error("map");
	a_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("idle");
	a_write_back: assert property (reg_wr && hit && !strap_load ##1 reg_rd && hit |=>
		reg_rdata[2:0] == $past(reg_wdata[2:0], 2)) else $error("wr");
	a_bp_off: assert property (reg_wr && hit && !reg_wdata[6] && !strap_load ##1
		!(reg_wr && hit) && !strap_load |=> !backpressure_active) else $error("bp");
	a_bp_bit: assert property (reg_rd && hit && backpressure_active |=> reg_rdata[6])
		else $error("bp6");
	a_status_mirror: assert property (reg_rd && hit |=>
		reg_rdata[4:3] == {$past(pause_rx_active), $past(pause_tx_active)}) else $error("st");
	a_strap_reload: assert property (strap_load ##1 reg_rd && hit |=>
		reg_rdata[6] == $past(backpressure_strap, 2) && reg_rdata[0] == $past(manual_select_strap, 2))
		else $error("strap");
	c_write: cover property (reg_wr && hit);
	c_strap: cover property (strap_load);
	c_bp: cover property (backpressure_active);
endmodule : fc_port2_checker
bind port2_flow_control_select fc_port2_checker chk (.*);

// ---- test/link_partner_model.sv ----
// Link partner model driving negotiation results and duplex
`timescale 1ns/1ns
module link_partner_model (
	input wire logic mclk, rst, an_on, adv_tx, adv_rx, half, slow,
	output logic an_enabled, an_complete, an_pause_tx, an_pause_rx, link_half_duplex
);
	logic [3:0] cnt_reg, cnt_next;
	// A slow partner needs 15 cycles, so the bench waits longer than that
	always_comb cnt_next = rst || !an_on ? 4'h0 : cnt_reg + {3'h0, cnt_reg != (slow ? 4'hf : 4'h1)};
	always_ff @(posedge mclk) cnt_reg <= cnt_next;
	assign an_enabled = an_on;
	assign an_complete = an_on && cnt_reg == (slow ? 4'hf : 4'h1);
	// Results toggle until negotiation completes, never a stale value
	assign an_pause_tx = an_complete ? adv_tx : cnt_reg[0];
	assign an_pause_rx = an_complete ? adv_rx : !cnt_reg[0];
	assign link_half_duplex = half;
endmodule : link_partner_model

// ---- test/port2_flow_control_select_tb.sv ----
// Random and corner tests of the port 2 flow control register
`timescale 1ns/1ns
module port2_flow_control_select_tb;
	logic mclk, rst, reg_wr, reg_rd, strap_load, an_on, adv_tx, adv_rx, half, slow;
	logic backpressure_strap, full_duplex_pause_strap, manual_select_strap, strap_duplex_half;
	logic strap_an_enable, an_enabled, an_complete, an_pause_tx, an_pause_rx, link_half_duplex;
	logic backpressure_active, pause_tx_active, pause_rx_active;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv, w, x, e;
	int mismatches, samples_checked;
	port2_flow_control_select DUT (.*);
	link_partner_model partner (.*);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction : xs
	function automatic logic [31:0] exp_reg(input logic [31:0] v);
		logic m;
		m = v[0] || !an_on;
		return {25'h0, v[6], half, !half && (m ? v[2] : adv_rx), !half && (m ? v[1] : adv_tx), v[2:0]};
	endfunction : exp_reg
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("FAIL %0t %h %h", $time, s, e);
		end
	endtask : check
	// Strobes stay up between calls so no signal is driven twice in one step
	task automatic acc(input logic [11:0] a, input logic wr, input logic [31:0] d);
		{reg_addr, reg_wr, reg_rd, reg_wdata} = {a, wr, !wr, d};
		@(negedge mclk);
		rv = reg_rdata;
	endtask : acc
	task automatic end_of_test;
		$display("%0d checks %0d mismatches", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		#20000;
		mismatches++;
		end_of_test();
	end
	initial begin
		x = 32'h42;
		{reg_wr, reg_rd, strap_load, an_on, adv_tx, adv_rx, half, slow, reg_addr, reg_wdata} = 52'h0;
		{backpressure_strap, full_duplex_pause_strap, manual_select_strap} = 3'h5;
		{strap_duplex_half, strap_an_enable, rst} = 3'h7;
		repeat (5) @(negedge mclk);
		rst = 1'b0;
		acc(12'h1a4, 1'b0, 32'h0);
		check(rv, 32'h61);
		for (int i = 0; i < 24; i++) begin
			x = xs(x);
			{slow, an_on, adv_tx, adv_rx, half} = x[4:0];
			w = i == 1 ? 32'hffff_ffff : x ^ (x >> 11);
			if (i % 4 == 0) begin
				{backpressure_strap, full_duplex_pause_strap, manual_select_strap} = x[10:8];
				w = {25'h0, x[10], 3'h0, {2{x[9]}}, x[8]};
				strap_load = 1'b1;
				@(negedge mclk);
				strap_load = 1'b0;
			end else begin
				acc({x[11:1], 1'b1}, 1'b1, ~w);
				acc(12'h1a4, 1'b1, w);
			end
			acc(12'h1a4, 1'b0, 32'h0);
			check(rv & 32'h47, w & 32'h47);
			{reg_wr, reg_rd} = 2'h0;
			repeat (20) @(negedge mclk);
			acc(12'h1a4, 1'b0, 32'h0);
			e = exp_reg(w);
			check(rv, e);
			check({29'h0, backpressure_active, pause_rx_active, pause_tx_active}, {29'h0, w[6] & half, e[4:3]});
			acc({x[23:13], 1'b1}, 1'b0, 32'h0);
			check(rv, 32'h0);
			$display("test %0d done", i);
		end
		end_of_test();
	end
endmodule : port2_flow_control_select_tb
